// ---- hw/dsc_defs.vh ----
// constants for the dac serial update control block
`ifndef DSC_DEFS_VH
`define DSC_DEFS_VH

// ------------------------------------------------------------
// frame geometry
// ------------------------------------------------------------
`define DSC_FRAME_SHORT 6'd24
`define DSC_FRAME_LONG 6'd32
`define DSC_CNT_MAX 6'd63
`define DSC_CMD_HI 23
`define DSC_CMD_LO 20
`define DSC_ADDR_HI 19
`define DSC_ADDR_LO 16
`define DSC_DATA_HI 15
`define DSC_DATA_LO 0
`define DSC_SPAN_HI 2

// ------------------------------------------------------------
// command codes (table kept here so it can be swapped)
// ------------------------------------------------------------
`define DSC_CMD_WR_A 4'h0
`define DSC_CMD_WR_B 4'h1
`define DSC_CMD_UPD 4'h2
`define DSC_CMD_WR_A_UPD 4'h3
`define DSC_CMD_UPD_ALL 4'h4
`define DSC_CMD_SPAN 4'h6
`define DSC_CMD_TSEL 4'h7
`define DSC_CMD_PD 4'h8
`define DSC_CMD_PD_ALL 4'h9

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define DSC_MIDSCALE 16'h8000
`define DSC_ZEROSCALE 16'h0000
`define DSC_MID_SEL_BIT 2
// sync vector: bit2 select, bit3 update, bit4 clear idle high
`define DSC_SYNC_INIT 9'h01c
`define DSC_SYNC_W 9

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
// cycles the cleared state is held after reset while synchronisers fill
`define DSC_INIT_CYCLES 3'd5

`endif

// ---- hw/dsc_sync3.v ----
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`include "dsc_defs.vh"

module dsc_sync3 #(
    parameter W = 9,
    parameter [W-1:0] INIT = {W{1'b0}}
) (
    // clock and reset
    input wire clock,
    input wire resetn,
    // asynchronous pins
    input wire [W-1:0] d,
    // filtered levels
    output wire [W-1:0] q
);

reg [W-1:0] s1_ff;
reg [W-1:0] s2_ff;
reg [W-1:0] s3_ff;
reg [W-1:0] q_ff;
reg [W-1:0] nxt_q;
integer i;

// ------------------------------------------------------------
// stages
// ------------------------------------------------------------
// first stage is read only by the second; filter looks at 2 and 3
always @(posedge clock) begin
    if (!resetn) begin
        s1_ff <= INIT;
        s2_ff <= INIT;
        s3_ff <= INIT;
        q_ff <= INIT;
    end else begin
        s1_ff <= d;
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
        q_ff <= nxt_q;
    end
end

// a change is taken only once stages two and three agree
always @* begin
    nxt_q = q_ff;
    for (i = 0; i < W; i = i + 1) begin
        if (s2_ff[i] == s3_ff[i]) begin
            nxt_q[i] = s3_ff[i];
        end
    end
end

assign q = q_ff;

endmodule

// ---- hw/dsc_core.v ----
// serial port, update, toggle and clear control of a sixteen-channel dac
`timescale 1ns/100ps
`include "dsc_defs.vh"


module dsc_core (
    // clock and reset
    input wire clock,
    input wire resetn,
    // serial port
    input wire select_load_n,
    input wire sck,
    input wire sdi,
    output wire sdo_out,
    output wire sdo_oe_n,
    // asynchronous control pins
    input wire async_update_n,
    input wire toggle_pin,
    input wire async_clear_n,
    // hardwired span pins
    input wire span_select_bit0,
    input wire span_select_bit1,
    input wire span_select_bit2,
    // channel state towards the converters
    output wire [255:0] dac_code_flat,
    output wire [47:0] span_flat,
    output wire [15:0] power_down,
    output wire [15:0] toggle_select
);

// ------------------------------------------------------------
// helpers
// ------------------------------------------------------------
// reset code picked by the span pins
function [15:0] reset_code;
    input [2:0] span;
    begin
        if (span[`DSC_MID_SEL_BIT]) begin
            reset_code = `DSC_MIDSCALE;
        end else begin
            reset_code = `DSC_ZEROSCALE;
        end
    end
endfunction

// ------------------------------------------------------------
// pin synchronisation
// ------------------------------------------------------------
wire [`DSC_SYNC_W-1:0] pins_raw;
wire [`DSC_SYNC_W-1:0] pins;

assign pins_raw = {span_select_bit2, span_select_bit1, span_select_bit0, toggle_pin,
    async_clear_n, async_update_n, select_load_n, sdi, sck};

dsc_sync3 #(
    .W(`DSC_SYNC_W),
    .INIT(`DSC_SYNC_INIT)
) u_dsc_sync3 (
    .clock(clock),
    .resetn(resetn),
    .d(pins_raw),
    .q(pins)
);

wire sck_s;
wire sdi_s;
wire sel_s;
wire upd_s;
wire clr_s;
wire tog_s;
wire [2:0] span_pins;

assign sck_s = pins[0];
assign sdi_s = pins[1];
assign sel_s = pins[2];
assign upd_s = pins[3];
assign clr_s = pins[4];
assign tog_s = pins[5];
assign span_pins = pins[8:6];

// ------------------------------------------------------------
// edge detection
// ------------------------------------------------------------
reg sck_prev_ff;
reg sel_prev_ff;
reg upd_prev_ff;
reg tog_prev_ff;

// edges come from filtered levels, so one pin edge gives one pulse
always @(posedge clock) begin
    if (!resetn) begin
        sck_prev_ff <= 1'b0;
        sel_prev_ff <= 1'b1;
        upd_prev_ff <= 1'b1;
        tog_prev_ff <= 1'b0;
    end else begin
        sck_prev_ff <= sck_s;
        sel_prev_ff <= sel_s;
        upd_prev_ff <= upd_s;
        tog_prev_ff <= tog_s;
    end
end

wire sck_rise;
wire sck_fall;
wire sel_rise;
wire upd_fall;
wire tog_rise;
wire tog_fall;

assign sck_rise = sck_s & ~sck_prev_ff;
assign sck_fall = ~sck_s & sck_prev_ff;
assign sel_rise = sel_s & ~sel_prev_ff;
assign upd_fall = ~upd_s & upd_prev_ff;
assign tog_rise = tog_s & ~tog_prev_ff;
assign tog_fall = ~tog_s & tog_prev_ff;

// ------------------------------------------------------------
// start-up hold
// ------------------------------------------------------------
reg [2:0] init_ff;
wire init_done;
wire in_clr;

// keep the cleared state until the span pins have passed the synchroniser
always @(posedge clock) begin
    if (!resetn) begin
        init_ff <= 3'd0;
    end else if (!init_done) begin
        init_ff <= init_ff + 3'd1;
    end
end

assign init_done = (init_ff == `DSC_INIT_CYCLES);
assign in_clr = !resetn || !init_done || !clr_s;

// ------------------------------------------------------------
// serial shift register
// ------------------------------------------------------------
reg [31:0] sr_ff;
reg out_hold_ff;
reg sdo_ff;
reg [5:0] cnt_ff;

// sck is ignored whenever select is high
always @(posedge clock) begin
    if (!resetn) begin
        sr_ff <= 32'h00000000;
        out_hold_ff <= 1'b0;
        sdo_ff <= 1'b0;
        cnt_ff <= 6'd0;
    end else begin
        if (sel_s) begin
            cnt_ff <= 6'd0;
        end
        if (!sel_s && sck_rise) begin
            sr_ff <= {sr_ff[30:0], sdi_s};
            out_hold_ff <= sr_ff[31];
            if (cnt_ff != `DSC_CNT_MAX) begin
                cnt_ff <= cnt_ff + 6'd1;
            end
        end
        if (!sel_s && sck_fall) begin
            sdo_ff <= out_hold_ff;
        end
    end
end

assign sdo_out = sdo_ff;
assign sdo_oe_n = sel_s;

// ------------------------------------------------------------
// command decode
// ------------------------------------------------------------
wire exec;
wire [3:0] cmd;
wire [3:0] addr;
wire [15:0] data;

// frames of any other length are dropped to protect the registers
assign exec = sel_rise && ((cnt_ff == `DSC_FRAME_SHORT) ||
    (cnt_ff == `DSC_FRAME_LONG));
assign cmd = sr_ff[`DSC_CMD_HI:`DSC_CMD_LO];
assign addr = sr_ff[`DSC_ADDR_HI:`DSC_ADDR_LO];
assign data = sr_ff[`DSC_DATA_HI:`DSC_DATA_LO];

// ------------------------------------------------------------
// channel registers
// ------------------------------------------------------------
reg [15:0] in_a_ff [0:15];
reg [15:0] in_b_ff [0:15];
reg [15:0] dac_ff [0:15];
reg [2:0] span_ff [0:15];
reg [15:0] pd_ff;
reg [15:0] tsel_ff;
reg upd_pend_ff;
wire pin_update;
integer i;

// a pending pin update fires one cycle after select rises, so a write
// executed on that rise is already in the input register
assign pin_update = (upd_fall && sel_s) || (upd_pend_ff && sel_s && !sel_rise);

// later statements win, clear overrides everything
always @(posedge clock) begin
    if (in_clr) begin
        for (i = 0; i < 16; i = i + 1) begin
            in_a_ff[i] <= reset_code(span_pins);
            in_b_ff[i] <= reset_code(span_pins);
            dac_ff[i] <= reset_code(span_pins);
            span_ff[i] <= span_pins;
        end
        pd_ff <= 16'h0000;
        tsel_ff <= 16'h0000;
        upd_pend_ff <= 1'b0;
    end else begin
        if (exec) begin
            case (cmd)
                `DSC_CMD_WR_A: begin
                    in_a_ff[addr] <= data;
                end
                `DSC_CMD_WR_B: begin
                    in_b_ff[addr] <= data;
                end
                `DSC_CMD_UPD: begin
                    dac_ff[addr] <= in_a_ff[addr];
                    pd_ff[addr] <= 1'b0;
                end
                `DSC_CMD_WR_A_UPD: begin
                    in_a_ff[addr] <= data;
                    dac_ff[addr] <= data;
                    pd_ff[addr] <= 1'b0;
                end
                `DSC_CMD_UPD_ALL: begin
                    for (i = 0; i < 16; i = i + 1) begin
                        dac_ff[i] <= in_a_ff[i];
                    end
                    pd_ff <= 16'h0000;
                end
                `DSC_CMD_SPAN: begin
                    span_ff[addr] <= data[`DSC_SPAN_HI:0];
                end
                `DSC_CMD_TSEL: begin
                    tsel_ff <= data;
                end
                `DSC_CMD_PD: begin
                    if (upd_s) begin
                        pd_ff[addr] <= 1'b1;
                    end
                end
                `DSC_CMD_PD_ALL: begin
                    if (upd_s) begin
                        pd_ff <= 16'hffff;
                    end
                end
                default: begin
                end
            endcase
        end
        // deferred pin update waits for the command to finish
        if (upd_fall && !sel_s) begin
            upd_pend_ff <= 1'b1;
        end else if (pin_update) begin
            upd_pend_ff <= 1'b0;
        end
        if (pin_update) begin
            for (i = 0; i < 16; i = i + 1) begin
                dac_ff[i] <= in_a_ff[i];
            end
        end
        // toggle edges act only on selected channels
        if (tog_fall || tog_rise) begin
            for (i = 0; i < 16; i = i + 1) begin
                if (tsel_ff[i]) begin
                    dac_ff[i] <= tog_fall ? in_a_ff[i] : in_b_ff[i];
                end
            end
        end
        if (!upd_s) begin
            pd_ff <= 16'h0000;
        end
    end
end

// ------------------------------------------------------------
// flattened outputs
// ------------------------------------------------------------
genvar g;
generate
    for (g = 0; g < 16; g = g + 1) begin : g_flat
        assign dac_code_flat[16*g+15:16*g] = dac_ff[g];
        assign span_flat[3*g+2:3*g] = span_ff[g];
    end
endgenerate

assign power_down = pd_ff;
assign toggle_select = tsel_ff;

endmodule

// ---- test/dsc_core_asserts.sv ----
// pin-level assertions for the dac serial update control block
`timescale 1ns/100ps
module dsc_core_asserts (
    // clock and reset
    input wire clock,
    input wire resetn,
    // pins
    input wire select_load_n,
    input wire sdo_oe_n,
    input wire async_update_n,
    input wire async_clear_n,
    input wire span_select_bit0,
    input wire span_select_bit1,
    input wire span_select_bit2,
    // channel state
    input wire [255:0] dac_code_flat,
    input wire [47:0] span_flat,
    input wire [15:0] power_down,
    input wire [15:0] toggle_select
);
    // pins reach the logic 4 clocks late, so every level is held 6 to 8 cycles first
    wire [2:0] span_pins = {span_select_bit2, span_select_bit1, span_select_bit0};
    wire [15:0] rst_code = span_select_bit2 ? 16'h8000 : 16'h0000;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    AST_SDO_RELEASE: assert property (select_load_n [*8] |-> sdo_oe_n)
        else $error("sdo driven while deselected");
    AST_SDO_DRIVE: assert property ((!select_load_n && async_clear_n) [*8] |-> !sdo_oe_n)
        else $error("sdo not driven in frame");
    AST_FRAME_HOLD: assert property ((!select_load_n && async_clear_n) [*8]
        |=> $stable(toggle_select)) else $error("register changed inside frame");
    AST_PD_HOLD: assert property ((select_load_n && async_update_n && async_clear_n) [*8]
        |=> $stable(power_down)) else $error("power down changed while idle");
    AST_UPD_POWERUP: assert property (!async_update_n [*6] |-> power_down == 16'h0000)
        else $error("channel powered down while update low");
    AST_CLR_CODE: assert property (!async_clear_n [*6] |-> dac_code_flat == {16{rst_code}})
        else $error("clear did not set reset code");
    AST_CLR_SPAN: assert property (!async_clear_n [*6] |-> span_flat == {16{span_pins}})
        else $error("clear did not set pin span");
    AST_CLR_CTRL: assert property (!async_clear_n [*6]
        |-> power_down == 16'h0000 && toggle_select == 16'h0000)
        else $error("clear left control registers set");

    // main scenarios reached
    cover property ($fell(async_update_n) && select_load_n);
    cover property ($rose(select_load_n));
    cover property (!async_clear_n [*6]);
endmodule

bind dsc_core dsc_core_asserts u_dsc_core_asserts (
    .clock(clock), .resetn(resetn), .select_load_n(select_load_n), .sdo_oe_n(sdo_oe_n),
    .async_update_n(async_update_n), .async_clear_n(async_clear_n),
    .span_select_bit0(span_select_bit0), .span_select_bit1(span_select_bit1),
    .span_select_bit2(span_select_bit2), .dac_code_flat(dac_code_flat),
    .span_flat(span_flat), .power_down(power_down), .toggle_select(toggle_select)
);

// ---- test/dsc_host_model.sv ----
// serial master model driving select, clock and data pins
`timescale 1ns/100ps
module dsc_host_model (
    // clock
    input wire clock,
    // serial pins
    output logic select_load_n,
    output logic sck,
    output logic sdi,
    input wire sdo_pin
);
    logic [31:0] echo;
    initial begin
        select_load_n = 1'b1;
        sck = 1'b0;
        sdi = 1'b0;
        echo = 32'h0;
    end
    // step n clocks then move off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // one frame msb first; sck idles low, period 8 clocks
    task automatic frame(input logic [31:0] w, input bit long);
        int i;
        tick(6);
        select_load_n = 1'b0;
        for (i = long ? 31 : 23; i >= 0; i--) begin
            sdi = w[i];
            tick(4);
            sck = 1'b1;
            tick(4);
            echo = {echo[30:0], sdo_pin}; // late sample: sdo follows the fall 5 clocks late
            sck = 1'b0;
        end
        tick(4);
        select_load_n = 1'b1;
        sdi = ~sdi; // released line must not show the last bit
    endtask
endmodule

// ---- test/tb_dac_serial_update_control.sv ----
// self-checking bench for the dac serial update control block
`timescale 1ns/100ps
module tb_dac_serial_update_control;
    logic clock;
    logic resetn;
    logic async_update_n;
    logic toggle_pin;
    logic async_clear_n;
    wire select_load_n, sck, sdi, sdo_out, sdo_oe_n;
    wire [255:0] dac_code_flat;
    wire [47:0] span_flat;
    wire [15:0] power_down, toggle_select;
    int miscompares = 0;
    int n_checks = 0;
    int cycles = 0;
    // span pins tied to 5: bit2 set means midscale reset code
    localparam logic [2:0] SPAN = 3'h5;
    localparam logic [15:0] RST = 16'h8000;
    wire sdo_pin = sdo_oe_n ? 1'bz : sdo_out;

    dsc_core u_dsc_core (.clock(clock), .resetn(resetn), .select_load_n(select_load_n),
        .sck(sck), .sdi(sdi), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n),
        .async_update_n(async_update_n), .toggle_pin(toggle_pin), .async_clear_n(async_clear_n),
        .span_select_bit0(SPAN[0]), .span_select_bit1(SPAN[1]), .span_select_bit2(SPAN[2]),
        .dac_code_flat(dac_code_flat), .span_flat(span_flat), .power_down(power_down),
        .toggle_select(toggle_select));
    dsc_host_model u_dsc_host_model (.clock(clock), .select_load_n(select_load_n),
        .sck(sck), .sdi(sdi), .sdo_pin(sdo_pin));

    task automatic check(input string what, input logic [255:0] seen, input logic [255:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [15:0] ch(input int n);
        return dac_code_flat[16*n +: 16];
    endfunction
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // 24-bit command, then time for select rise to be seen and executed
    task automatic cmd(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d);
        u_dsc_host_model.frame({8'h00, c, a, d}, 1'b0);
        wait_clk(8);
    endtask

    task automatic test_reset;
        check("span", span_flat, {16{SPAN}});
        check("codes", dac_code_flat, {16{RST}});
        check("ctrl", {power_down, toggle_select}, 0);
    endtask
    task automatic test_serial;
        cmd(4'h3, 4'h5, 16'h1234);
        check("ch5", ch(5), 16'h1234);
        check("ch4", ch(4), RST);
        u_dsc_host_model.frame(32'ha502abcd, 1'b1);
        u_dsc_host_model.frame(32'h3c125555, 1'b1);
        wait_clk(8);
        check("echo", u_dsc_host_model.echo[30:0], 31'h2502abcd >> 1 | 31'h40000000);
        check("ch2 write only", ch(2), RST);
        cmd(4'h4, 4'h0, 16'h0000);
        check("ch2 update all", ch(2), 16'habcd);
        cmd(4'h7, 4'h0, 16'h0004);
        toggle_pin = 1'b1;
        wait_clk(8);
        check("toggle rise", ch(2), 16'h5555);
        check("unselected", ch(5), 16'h1234);
        toggle_pin = 1'b0;
        wait_clk(8);
        check("toggle fall", ch(2), 16'habcd);
    endtask
    task automatic test_update;
        fork
            u_dsc_host_model.frame({8'h00, 4'h0, 4'h7, 16'h0777}, 1'b0);
            begin
                wait_clk(40);
                async_update_n = 1'b0;
            end
        join
        check("ch7 deferred", ch(7), RST);
        wait_clk(8);
        check("ch7 applied", ch(7), 16'h0777);
        cmd(4'h8, 4'h3, 16'h0000);
        check("pd ignored", power_down, 16'h0000);
        async_update_n = 1'b1;
        cmd(4'h8, 4'h3, 16'h0000);
        check("pd taken", power_down, 16'h0008);
        cmd(4'h0, 4'hb, 16'h0bbb);
        async_update_n = 1'b0;
        wait_clk(8);
        check("pin update", ch(11), 16'h0bbb);
        check("power up", power_down, 16'h0000);
        async_update_n = 1'b1;
    endtask
    // power-down all, a single-channel update and a span write
    task automatic test_cmds;
        cmd(4'h9, 4'h0, 16'h0000);
        check("pd all", power_down, 16'hffff);
        cmd(4'h0, 4'h6, 16'h0666);
        check("ch6 write only", ch(6), RST);
        cmd(4'h2, 4'h6, 16'h0000);
        check("ch6 update", ch(6), 16'h0666);
        check("pd ch6 up", power_down, 16'hffbf);
        cmd(4'h6, 4'h1, 16'h0002);
        check("span ch1", span_flat[5:3], 3'h2);
        check("span ch0", span_flat[2:0], SPAN);
    endtask
    task automatic test_clear;
        async_clear_n = 1'b0;
        wait_clk(8);
        check("clear codes", dac_code_flat, {16{RST}});
        check("clear span", span_flat, {16{SPAN}});
        check("clear pd", power_down, 16'h0000);
        check("clear tsel", toggle_select, 16'h0000);
        async_clear_n = 1'b1;
        wait_clk(8);
    endtask

    task automatic complete_run;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // free-running clock and a hang guard
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            complete_run;
        end
    end
    // main sequence
    initial begin
        resetn = 1'b0;
        async_update_n = 1'b1;
        toggle_pin = 1'b0;
        async_clear_n = 1'b1;
        wait_clk(4);
        resetn = 1'b1;
        wait_clk(8);
        test_reset;
        test_serial;
        test_update;
        test_cmds;
        test_clear;
        complete_run;
    end
endmodule
